// file: src/ebs_pkg.sv
// Shared constants and types for the elevator brake sequencer
package ebs_pkg;
  // Sequence time base: one tick is 0.01 s
  localparam int unsigned TICK_US = 10000;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_ZERO_SPEED = 8'h04;
  localparam logic [7:0] OFS_INJ_CURRENT = 8'h08;
  localparam logic [7:0] OFS_INJ_TIME = 8'h0C;
  localparam logic [7:0] OFS_BRAKE_DELAY = 8'h10;
  localparam logic [7:0] OFS_CONT_DELAY = 8'h14;
  localparam logic [7:0] OFS_HOLD_GAIN = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  // Field positions: low field at bit 0, high field here
  localparam int unsigned HI_LSB = 16;
  localparam int unsigned TUNE_SEL_BIT = 4;
  // Limits: levels in 0.01 Hz, times in ticks, currents in percent
  localparam logic [9:0] MAX_LEVEL = 10'h3E8;
  localparam logic [9:0] MAX_LONG_TIME = 10'h3E8;
  localparam logic [9:0] MAX_SHORT_TIME = 10'h064;
  localparam logic [9:0] MAX_PCT = 10'h064;
  localparam logic [1:0] MODE_CLOSED_LOOP = 2'h3;
  // Values after reset
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic RST_TUNE_SEL = 1'b0;
  localparam logic [9:0] RST_START_LEVEL = 10'h014;
  localparam logic [9:0] RST_STOP_LEVEL = 10'h014;
  localparam logic [6:0] RST_START_CUR = 7'h64;
  localparam logic [6:0] RST_STOP_CUR = 7'h64;
  localparam logic [9:0] RST_START_INJ = 10'h028;
  localparam logic [9:0] RST_STOP_INJ = 10'h03C;
  localparam logic [9:0] RST_BRAKE_REL = 10'h014;
  localparam logic [9:0] RST_BRAKE_CLOSE = 10'h01E;
  localparam logic [6:0] RST_RUN_DELAY = 7'h14;
  localparam logic [6:0] RST_OPEN_DELAY = 7'h14;
  localparam logic [6:0] RST_HOLD_GAIN = 7'h03;

  typedef enum {ST_IDLE, ST_CONTACT, ST_START_INJ, ST_ACCEL, ST_DECEL, ST_STOP_INJ,
                ST_BRAKE_HOLD, ST_OUT_OFF} ebs_state_t;

  typedef struct packed {
    logic [1:0] control_mode_select;
    logic contactor_during_tuning_sel;
    logic [9:0] start_zero_speed_level;
    logic [9:0] stop_zero_speed_level;
    logic [6:0] start_injection_current;
    logic [6:0] stop_injection_current;
    logic [9:0] start_injection_time;
    logic [9:0] stop_injection_time;
    logic [9:0] brake_release_delay;
    logic [9:0] brake_close_delay;
    logic [6:0] run_command_delay;
    logic [6:0] contactor_open_delay;
    logic [6:0] hold_gain_at_start;
    logic [6:0] hold_gain_at_stop;
  } ebs_cfg_t;

  typedef struct packed {
    logic dc_inject;
    logic [6:0] inject_current;
    logic accel_enable;
    logic [9:0] start_freq;
    logic lock_enable;
    logic [6:0] lock_gain;
  } ebs_drive_t;
endpackage : ebs_pkg

// file: src/ebs_tick.sv
// Tick divider for the sequence time base
`timescale 1ns/100ps
module ebs_tick #(
  parameter int unsigned CYCLES = ebs_pkg::TICK_CYC
) (
  input wire logic clk_i,  // System clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic clr_i,  // Restart the tick period
  output logic tick_o      // One-cycle tick pulse
);
  localparam logic [20:0] LAST = 21'(CYCLES - 1);
  logic [20:0] cnt_r;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_r <= 21'h000000;
      tick_o <= 1'b0;
    end
    else if (clr_i)
    begin
      cnt_r <= 21'h000000;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_r <= (cnt_r == LAST) ? 21'h000000 : cnt_r + 21'h000001;
      tick_o <= (cnt_r == LAST);
    end
  end
endmodule : ebs_tick

// file: src/ebs_seq.sv
// Elevator brake sequencer: start/stop sequence with APB parameter registers
//
// Functional notes
// - Acceleration begins from the start zero-speed level after start injection.
// - Stop injection begins when output frequency falls to stop zero-speed level.
// - Start injection current is a settable percentage, default 100.
// - Stop injection current is a separate settable percentage, default 100.
// - Start injection lasts its set time, default 0.40 s; zero skips it.
// - Stop injection lasts its set time, default 0.60 s; zero skips it.
// - Brake releases only after its delay from travel command acceptance.
// - Brake stays released for its close delay after zero speed.
// - Output starts only after run command delay, letting the contactor close; a command dropped in ST_CONTACT goes to ST_DECEL with output on.
// - Contactor opens only after its delay once output is shut off.
// - During tuning contactor closes only when the tuning select is 1.
// - Position lock gains apply only in closed-loop control mode 3.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module ebs_seq #(
  parameter int unsigned TICK_CYCLES = ebs_pkg::TICK_CYC
) (
  input wire logic clk_i,              // System clock, 125 MHz
  input wire logic nrst_i,             // Async reset, active low
  input wire logic psel_i,             // APB select
  input wire logic penable_i,          // APB enable
  input wire logic pwrite_i,           // APB write
  input wire logic [7:0] paddr_i,      // APB byte address
  input wire logic [31:0] pwdata_i,    // APB write data
  output logic [31:0] prdata_o,        // APB read data
  output logic pready_o,               // APB ready
  output logic pslverr_o,              // APB error
  input wire logic up_i,               // Travel up command pin
  input wire logic down_i,             // Travel down command pin
  input wire logic tune_i,             // Auto-tuning in progress pin
  input wire logic [13:0] out_freq_i,  // Output frequency, 0.01 Hz
  output logic contactor_o,            // Motor contactor close
  output logic brake_release_o,        // Brake release
  output logic output_on_o,            // Drive output enabled
  output ebs_pkg::ebs_drive_t drive_o  // Injection, accel and lock controls
);
  ebs_pkg::ebs_cfg_t cfg_r;
  ebs_pkg::ebs_state_t state_r;
  ebs_pkg::ebs_state_t state_nxt;
  logic [1:0] up_sync_r;
  logic [1:0] down_sync_r;
  logic [1:0] tune_sync_r;
  logic cmd;
  logic tick;
  logic tick_clr;
  logic [9:0] ph_tmr_r;
  logic [9:0] ph_tmr_nxt;
  logic [9:0] brk_tmr_r;
  logic brk_closing_r;
  logic brk_on_r;
  logic ph_done;
  logic brk_done;
  logic accept;
  logic zero_hit;
  logic apb_done;

  // Keep a write inside its documented range
  function automatic logic [9:0] clip(input logic [9:0] v, input logic [9:0] lim);
    clip = (v > lim) ? lim : v;
  endfunction : clip

  function automatic logic [6:0] clip7(input logic [6:0] v, input logic [9:0] lim);
    logic [9:0] w;
    w = clip({3'h0, v}, lim);
    clip7 = w[6:0];
  endfunction : clip7

  // Two-stage sync on pins; stage 2 onward feeds logic
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      up_sync_r <= 2'h0;
      down_sync_r <= 2'h0;
      tune_sync_r <= 2'h0;
    end
    else
    begin
      up_sync_r <= {up_sync_r[0], up_i};
      down_sync_r <= {down_sync_r[0], down_i};
      tune_sync_r <= {tune_sync_r[0], tune_i};
    end
  end

  assign cmd = up_sync_r[1] | down_sync_r[1];
  assign accept = (state_r == ebs_pkg::ST_IDLE) && cmd;
  assign zero_hit = (state_r == ebs_pkg::ST_DECEL) &&
                    (out_freq_i <= {4'h0, cfg_r.stop_zero_speed_level});
  // Both counters restart aligned to the tick at acceptance and at zero speed
  assign tick_clr = accept | zero_hit;
  assign ph_done = (ph_tmr_r == 10'h000);
  assign brk_done = brk_closing_r && (brk_tmr_r == 10'h000);

  ebs_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .clr_i(tick_clr),
    .tick_o(tick)
  );

  // APB slave: one wait state, answer registered with pready
  assign apb_done = psel_i && penable_i && pready_o;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end
    else
    begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
      if (psel_i && penable_i && !pready_o)
      begin
        if (paddr_i == ebs_pkg::OFS_MODE)
          prdata_o <= 32'({cfg_r.contactor_during_tuning_sel, 2'h0,
                           cfg_r.control_mode_select});
        else if (paddr_i == ebs_pkg::OFS_ZERO_SPEED)
          prdata_o <= {6'h00, cfg_r.stop_zero_speed_level, 6'h00,
                       cfg_r.start_zero_speed_level};
        else if (paddr_i == ebs_pkg::OFS_INJ_CURRENT)
          prdata_o <= {9'h000, cfg_r.stop_injection_current, 9'h000,
                       cfg_r.start_injection_current};
        else if (paddr_i == ebs_pkg::OFS_INJ_TIME)
          prdata_o <= {6'h00, cfg_r.stop_injection_time, 6'h00,
                       cfg_r.start_injection_time};
        else if (paddr_i == ebs_pkg::OFS_BRAKE_DELAY)
          prdata_o <= {6'h00, cfg_r.brake_close_delay, 6'h00,
                       cfg_r.brake_release_delay};
        else if (paddr_i == ebs_pkg::OFS_CONT_DELAY)
          prdata_o <= {9'h000, cfg_r.contactor_open_delay, 9'h000,
                       cfg_r.run_command_delay};
        else if (paddr_i == ebs_pkg::OFS_HOLD_GAIN)
          prdata_o <= {9'h000, cfg_r.hold_gain_at_stop, 9'h000,
                       cfg_r.hold_gain_at_start};
        else if (paddr_i == ebs_pkg::OFS_STATUS)
        begin
          prdata_o <= 32'({brk_on_r, output_on_o, contactor_o, 4'(state_r)});
          pslverr_o <= pwrite_i;
        end
        else
          pslverr_o <= 1'b1;
      end
    end
  end

  // Parameter writes, clipped to range; times take effect at the next phase load, levels, currents, gains and mode at once
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg_r.control_mode_select <= ebs_pkg::RST_MODE;
      cfg_r.contactor_during_tuning_sel <= ebs_pkg::RST_TUNE_SEL;
      cfg_r.start_zero_speed_level <= ebs_pkg::RST_START_LEVEL;
      cfg_r.stop_zero_speed_level <= ebs_pkg::RST_STOP_LEVEL;
      cfg_r.start_injection_current <= ebs_pkg::RST_START_CUR;
      cfg_r.stop_injection_current <= ebs_pkg::RST_STOP_CUR;
      cfg_r.start_injection_time <= ebs_pkg::RST_START_INJ;
      cfg_r.stop_injection_time <= ebs_pkg::RST_STOP_INJ;
      cfg_r.brake_release_delay <= ebs_pkg::RST_BRAKE_REL;
      cfg_r.brake_close_delay <= ebs_pkg::RST_BRAKE_CLOSE;
      cfg_r.run_command_delay <= ebs_pkg::RST_RUN_DELAY;
      cfg_r.contactor_open_delay <= ebs_pkg::RST_OPEN_DELAY;
      cfg_r.hold_gain_at_start <= ebs_pkg::RST_HOLD_GAIN;
      cfg_r.hold_gain_at_stop <= ebs_pkg::RST_HOLD_GAIN;
    end
    else if (apb_done && pwrite_i)
    begin
      if (paddr_i == ebs_pkg::OFS_MODE)
      begin
        cfg_r.control_mode_select <= pwdata_i[1:0];
        cfg_r.contactor_during_tuning_sel <= pwdata_i[ebs_pkg::TUNE_SEL_BIT];
      end
      else if (paddr_i == ebs_pkg::OFS_ZERO_SPEED)
      begin
        cfg_r.start_zero_speed_level <= clip(pwdata_i[9:0], ebs_pkg::MAX_LEVEL);
        cfg_r.stop_zero_speed_level <= clip(pwdata_i[ebs_pkg::HI_LSB +: 10],
                                            ebs_pkg::MAX_LEVEL);
      end
      else if (paddr_i == ebs_pkg::OFS_INJ_CURRENT)
      begin
        cfg_r.start_injection_current <= clip7(pwdata_i[6:0], ebs_pkg::MAX_PCT);
        cfg_r.stop_injection_current <= clip7(pwdata_i[ebs_pkg::HI_LSB +: 7],
                                              ebs_pkg::MAX_PCT);
      end
      else if (paddr_i == ebs_pkg::OFS_INJ_TIME)
      begin
        cfg_r.start_injection_time <= clip(pwdata_i[9:0], ebs_pkg::MAX_LONG_TIME);
        cfg_r.stop_injection_time <= clip(pwdata_i[ebs_pkg::HI_LSB +: 10],
                                          ebs_pkg::MAX_LONG_TIME);
      end
      else if (paddr_i == ebs_pkg::OFS_BRAKE_DELAY)
      begin
        cfg_r.brake_release_delay <= clip(pwdata_i[9:0], ebs_pkg::MAX_LONG_TIME);
        cfg_r.brake_close_delay <= clip(pwdata_i[ebs_pkg::HI_LSB +: 10],
                                        ebs_pkg::MAX_LONG_TIME);
      end
      else if (paddr_i == ebs_pkg::OFS_CONT_DELAY)
      begin
        cfg_r.run_command_delay <= clip7(pwdata_i[6:0], ebs_pkg::MAX_SHORT_TIME);
        cfg_r.contactor_open_delay <= clip7(pwdata_i[ebs_pkg::HI_LSB +: 7],
                                            ebs_pkg::MAX_SHORT_TIME);
      end
      else if (paddr_i == ebs_pkg::OFS_HOLD_GAIN)
      begin
        cfg_r.hold_gain_at_start <= clip7(pwdata_i[6:0], ebs_pkg::MAX_PCT);
        cfg_r.hold_gain_at_stop <= clip7(pwdata_i[ebs_pkg::HI_LSB +: 7],
                                         ebs_pkg::MAX_PCT);
      end
    end
  end

  // Sequence; a command dropped early still stops through the ramp path
  always_comb
  begin
    state_nxt = state_r;
    ph_tmr_nxt = (tick && !ph_done) ? ph_tmr_r - 10'h001 : ph_tmr_r;
    case (state_r)
      ebs_pkg::ST_IDLE:
        if (cmd)
        begin
          state_nxt = ebs_pkg::ST_CONTACT;
          ph_tmr_nxt = {3'h0, cfg_r.run_command_delay};
        end
      ebs_pkg::ST_CONTACT:
        if (!cmd)
          state_nxt = ebs_pkg::ST_DECEL;
        else if (ph_done && cfg_r.start_injection_time == 10'h000)
          state_nxt = ebs_pkg::ST_ACCEL;
        else if (ph_done)
        begin
          state_nxt = ebs_pkg::ST_START_INJ;
          ph_tmr_nxt = cfg_r.start_injection_time;
        end
      ebs_pkg::ST_START_INJ:
        if (!cmd)
          state_nxt = ebs_pkg::ST_DECEL;
        else if (ph_done)
          state_nxt = ebs_pkg::ST_ACCEL;
      ebs_pkg::ST_ACCEL:
        if (!cmd)
          state_nxt = ebs_pkg::ST_DECEL;
      ebs_pkg::ST_DECEL:
        if (zero_hit && cfg_r.stop_injection_time == 10'h000)
          state_nxt = ebs_pkg::ST_BRAKE_HOLD;
        else if (zero_hit)
        begin
          state_nxt = ebs_pkg::ST_STOP_INJ;
          ph_tmr_nxt = cfg_r.stop_injection_time;
        end
      ebs_pkg::ST_STOP_INJ:
        if (ph_done)
          state_nxt = ebs_pkg::ST_BRAKE_HOLD;
      ebs_pkg::ST_BRAKE_HOLD:
        if (brk_done)
        begin
          state_nxt = ebs_pkg::ST_OUT_OFF;
          ph_tmr_nxt = {3'h0, cfg_r.contactor_open_delay};
        end
      ebs_pkg::ST_OUT_OFF:
        if (ph_done)
          state_nxt = ebs_pkg::ST_IDLE;
      default:
        state_nxt = ebs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r <= ebs_pkg::ST_IDLE;
      ph_tmr_r <= 10'h000;
    end
    else
    begin
      state_r <= state_nxt;
      ph_tmr_r <= ph_tmr_nxt;
    end
  end

  // Brake timer: release delay from acceptance, close delay from zero speed
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      brk_tmr_r <= 10'h000;
      brk_closing_r <= 1'b0;
      brk_on_r <= 1'b0;
    end
    else if (accept)
    begin
      brk_tmr_r <= cfg_r.brake_release_delay;
      brk_closing_r <= 1'b0;
    end
    else if (zero_hit)
    begin
      brk_tmr_r <= cfg_r.brake_close_delay;
      brk_closing_r <= 1'b1;
    end
    else
    begin
      if (tick && brk_tmr_r != 10'h000)
        brk_tmr_r <= brk_tmr_r - 10'h001;
      if (state_r == ebs_pkg::ST_IDLE)
        brk_on_r <= 1'b0;
      else if (brk_done)
        brk_on_r <= 1'b0;
      // Never release once stopping, even if the release delay ran late
      else if (!brk_closing_r && brk_tmr_r == 10'h000 &&
               state_r != ebs_pkg::ST_DECEL)
        brk_on_r <= 1'b1;
    end
  end

  // Registered outputs, one cycle behind the state
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      contactor_o <= 1'b0;
      brake_release_o <= 1'b0;
      output_on_o <= 1'b0;
      drive_o <= '0;
    end
    else
    begin
      contactor_o <= (state_r != ebs_pkg::ST_IDLE) ||
                     (tune_sync_r[1] && cfg_r.contactor_during_tuning_sel);
      brake_release_o <= brk_on_r;
      output_on_o <= state_r inside {ebs_pkg::ST_START_INJ, ebs_pkg::ST_ACCEL,
                                     ebs_pkg::ST_DECEL, ebs_pkg::ST_STOP_INJ,
                                     ebs_pkg::ST_BRAKE_HOLD};
      drive_o.dc_inject <= state_r inside {ebs_pkg::ST_START_INJ, ebs_pkg::ST_STOP_INJ};
      drive_o.inject_current <= (state_r == ebs_pkg::ST_STOP_INJ) ?
                                cfg_r.stop_injection_current :
                                cfg_r.start_injection_current;
      drive_o.accel_enable <= (state_r == ebs_pkg::ST_ACCEL);
      drive_o.start_freq <= cfg_r.start_zero_speed_level;
      // Position lock only holds in closed-loop mode
      drive_o.lock_enable <= (cfg_r.control_mode_select == ebs_pkg::MODE_CLOSED_LOOP) &&
                             (state_r inside {ebs_pkg::ST_START_INJ,
                                              ebs_pkg::ST_STOP_INJ});
      drive_o.lock_gain <= (cfg_r.control_mode_select != ebs_pkg::MODE_CLOSED_LOOP) ?
                           7'h00 : (state_r == ebs_pkg::ST_STOP_INJ) ?
                           cfg_r.hold_gain_at_stop : cfg_r.hold_gain_at_start;
    end
  end

  sequence accept_s;
    (state_r == ebs_pkg::ST_IDLE) && cmd;
  endsequence

  sequence contact_wait_s;
    (state_r == ebs_pkg::ST_CONTACT) ##1 contactor_o;
  endsequence

  AST_ACCEPT_CONTACT: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept_s |=> contact_wait_s)
    else $error("contactor not closed after command acceptance");

  AST_OUTPUT_NEEDS_CONTACTOR: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    output_on_o |-> contactor_o)
    else $error("output on without contactor");

  AST_RUN_DELAY_HELD: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (state_r == ebs_pkg::ST_CONTACT && !ph_done && cmd) |=>
    state_r == ebs_pkg::ST_CONTACT)
    else $error("run delay cut short");

  AST_START_SKIP: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (state_r == ebs_pkg::ST_CONTACT && ph_done && cmd &&
     cfg_r.start_injection_time == 10'h000) |=> state_r == ebs_pkg::ST_ACCEL)
    else $error("zero start injection not skipped");

  AST_STOP_INJ_ON_ZERO: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (zero_hit && cfg_r.stop_injection_time != 10'h000) |=>
    state_r == ebs_pkg::ST_STOP_INJ ##1 drive_o.dc_inject)
    else $error("stop injection not started at zero speed");

  AST_BRAKE_WAITS_DELAY: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    $rose(brk_on_r) |-> $past(brk_tmr_r) == 10'h000 && !brk_closing_r)
    else $error("brake released before its delay");

  AST_OFF_AFTER_BRAKE: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    $fell(output_on_o) |-> !brake_release_o && $past(state_r, 2) == ebs_pkg::ST_BRAKE_HOLD)
    else $error("output shut off before brake close");

  AST_CONTACTOR_LAST: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (state_r == ebs_pkg::ST_OUT_OFF && !ph_done) |=> state_r == ebs_pkg::ST_OUT_OFF)
    else $error("contactor opened before its delay");

  AST_LOCK_MODE: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    drive_o.lock_enable |-> $past(cfg_r.control_mode_select) == ebs_pkg::MODE_CLOSED_LOOP)
    else $error("position lock outside closed-loop mode");

  AST_TUNE_CONTACTOR: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (state_r == ebs_pkg::ST_IDLE && tune_sync_r[1] && !cfg_r.contactor_during_tuning_sel
     ##1 state_r == ebs_pkg::ST_IDLE) |=> !contactor_o)
    else $error("contactor closed in tuning while disabled");
endmodule : ebs_seq

// file: verif/ebs_motor_model.sv
// Behavioural motor and output frequency model for the sequencer bench
`timescale 1ns/100ps
module ebs_motor_model (
  input wire logic clk_i,        // System clock
  input wire logic nrst_i,       // Async reset, active low
  input wire logic output_on_i,  // Drive output enabled
  input wire logic accel_i,      // Acceleration allowed
  output logic [13:0] out_freq_o // Output frequency, 0.01 Hz
);
  // Coarse ramp so zero speed is crossed within tens of cycles
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      out_freq_o <= 14'h0000;
    else if (!output_on_i)
      out_freq_o <= 14'h0000;
    else if (accel_i && out_freq_o < 14'h01F4)
      out_freq_o <= out_freq_o + 14'h0019;
    else if (!accel_i && out_freq_o != 14'h0000)
      out_freq_o <= out_freq_o - 14'h0019;
  end
endmodule : ebs_motor_model

// file: verif/tb_top.sv
// Self-checking bench for the elevator brake sequencer
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic up_i = 1'b0;
  logic down_i = 1'b0;
  logic tune_i = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [13:0] out_freq_i;
  logic contactor_o;
  logic brake_release_o;
  logic output_on_o;
  ebs_pkg::ebs_drive_t drive_o;
  logic [31:0] rd_d;
  logic rd_e;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;

  ebs_seq #(.TICK_CYCLES(10)) uut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .up_i(up_i),
    .down_i(down_i), .tune_i(tune_i), .out_freq_i(out_freq_i), .contactor_o(contactor_o),
    .brake_release_o(brake_release_o), .output_on_o(output_on_o), .drive_o(drive_o));
  ebs_motor_model partner (.clk_i(clk_i), .nrst_i(nrst_i), .output_on_i(output_on_o),
    .accel_i(drive_o.accel_enable), .out_freq_o(out_freq_i));

  always #4 clk_i = ~clk_i;

  task close_out;
    begin
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask : close_out

  // Run is several hundred cycles; ceiling leaves wide margin
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      close_out;
    end
  end

  task chk32(input logic [31:0] got, input logic [31:0] exp);
    begin
      comparisons++;
      if (got !== exp)
      begin
        error_cnt++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask : chk32

  task chk_rng(input int v, input int lo, input int hi);
    begin
      comparisons++;
      if (v < lo || v > hi)
      begin
        error_cnt++;
        $display("mismatch at %0t: interval %0d not in %0d..%0d", $time, v, lo, hi);
      end
    end
  endtask : chk_rng

  // Idle cycle before each setup keeps one assignment per step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    begin
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i iff pready_o === 1'b1);
      rd_d = prdata_o;
      rd_e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask : apb

  task regs;
    logic [7:0] adr [6];
    logic [31:0] exp [6];
    begin
      adr = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
      exp = '{32'h0014_0014, 32'h0064_0064, 32'h003C_0028, 32'h001E_0014,
              32'h0014_0014, 32'h0003_0003};
      for (int i = 0; i < 6; i++)
      begin
        apb(1'b0, adr[i], 32'h0);
        chk32(rd_d, exp[i]);
      end
      // Idle status: state 0, contactor, output and brake all off
      apb(1'b0, 8'h1C, 32'h0);
      chk32(rd_d, 32'h0000_0000);
      chk32({31'h0, rd_e}, 32'h0);
      apb(1'b1, 8'h18, 32'h00FF_00FF);
      apb(1'b0, 8'h18, 32'h0);
      chk32(rd_d, 32'h0064_0064);
      apb(1'b1, 8'h20, 32'h1);
      chk32({31'h0, rd_e}, 32'h1);
      apb(1'b1, 8'h1C, 32'h1);
      chk32({31'h0, rd_e}, 32'h1);
      apb(1'b1, 8'h04, 32'h000A_001E);
      apb(1'b1, 8'h08, 32'h0032_004B);
      apb(1'b1, 8'h0C, 32'h0002_0005);
      apb(1'b1, 8'h10, 32'h0006_0004);
      apb(1'b1, 8'h14, 32'h0003_0003);
      apb(1'b1, 8'h18, 32'h0009_0007);
      $display("test regs done");
    end
  endtask : regs

  task tune_test;
    begin
      for (int s = 0; s < 2; s++)
      begin
        apb(1'b1, 8'h00, s[0] ? 32'h10 : 32'h0);
        tune_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk32({31'h0, contactor_o}, {31'h0, s[0]});
        tune_i <= 1'b0;
        repeat (10) @(posedge clk_i);
      end
      $display("test tune done");
    end
  endtask : tune_test

  // One full travel: start sequence, then stop sequence
  task run(input logic dn, input logic [6:0] gain);
    int t0;
    int t1;
    begin
      @(posedge clk_i);
      up_i <= !dn;
      down_i <= dn;
      @(posedge clk_i iff contactor_o === 1'b1);
      t0 = cyc;
      @(posedge clk_i iff output_on_o === 1'b1);
      chk_rng(cyc - t0, 25, 45);
      repeat (3) @(posedge clk_i);
      chk32({25'h0, drive_o.inject_current}, 32'h4B);
      chk32({25'h0, drive_o.lock_gain}, {25'h0, gain});
      chk32({31'h0, drive_o.lock_enable}, {31'h0, gain != 7'h00});
      @(posedge clk_i iff brake_release_o === 1'b1);
      chk_rng(cyc - t0, 35, 50);
      @(posedge clk_i iff drive_o.accel_enable === 1'b1);
      chk_rng(cyc - t0, 75, 100);
      chk32({22'h0, drive_o.start_freq}, 32'h1E);
      repeat (20) @(posedge clk_i);
      up_i <= 1'b0;
      down_i <= 1'b0;
      @(posedge clk_i iff drive_o.dc_inject === 1'b1);
      t1 = cyc;
      chk32({31'h0, out_freq_i <= 14'h000A}, 32'h1);
      chk32({25'h0, drive_o.inject_current}, 32'h32);
      @(posedge clk_i iff brake_release_o === 1'b0);
      chk_rng(cyc - t1, 55, 75);
      t1 = cyc;
      @(posedge clk_i iff output_on_o === 1'b0);
      chk_rng(cyc - t1, 0, 5);
      t1 = cyc;
      @(posedge clk_i iff contactor_o === 1'b0);
      chk_rng(cyc - t1, 25, 45);
      $display("test run dir %0d done", dn);
    end
  endtask : run

  initial
  begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    regs;
    tune_test;
    run(1'b0, 7'h00);
    apb(1'b1, 8'h00, 32'h3);
    run(1'b1, 7'h07);
    close_out;
  end
endmodule : tb_top
